/* design/css_sequencer.sv */
/*
  Converter start-up sequencer and output setpoint selector.
  Assumes one 40 MHz clock; strap, enable and resistor-index inputs are
  asynchronous to it and are synchronised here, bus inputs are not. Analog classification
  of pins is done outside; this block receives the class codes.
  TICK_CYCLES keeps its package default in silicon; a shorter tick only
  compresses every interval for fast simulation.
*/
`timescale 1ns/100ps
module css_sequencer #(
  parameter int unsigned TICK_CYCLES = css_pkg::TICK_CYCLES  // Clocks per millisecond tick
) (
  input  wire logic                          ref_clk_i,
  input  wire logic                          resetn_i,
  input  wire logic                          enable_i,
  input  wire logic [1:0]                    output_setpoint_strap_i,
  input  wire logic [css_pkg::RES_IDX_W-1:0] setpoint_res_idx_i,
  input  wire logic                          nvm_valid_i,
  input  wire logic [css_pkg::MV_W-1:0]      nvm_target_mv_i,
  input  wire logic [css_pkg::MS_W-1:0]      nvm_delay_ms_i,
  input  wire logic [css_pkg::MS_W-1:0]      nvm_ramp_ms_i,
  input  wire logic [css_pkg::MS_W-1:0]      ss_delay_ms_i,
  input  wire logic [css_pkg::MS_W-1:0]      ss_ramp_ms_i,
  input  wire logic                          bus_wr_i,
  input  wire logic [1:0]                    bus_addr_i,
  input  wire logic [15:0]                   bus_wdata_i,
  input  wire logic                          bus_rd_i,
  output logic      [15:0]                   bus_rdata_o,
  output logic                               ready_o,
  output logic                               ramp_o,
  output logic                               output_on_o,
  output logic      [css_pkg::MV_W-1:0]      target_mv_o,
  output logic      [css_pkg::MV_W:0]        output_ceiling_limit_o
);

  localparam logic [1:0] A_TARGET  = 2'h0;
  localparam logic [1:0] A_DELAY   = 2'h1;
  localparam logic [1:0] A_RESTORE = 2'h2;
  localparam logic [1:0] A_STATUS  = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic        en_s1_r;
  logic        en_s2_r;
  logic [1:0]  sp_s1_r;
  logic [1:0]  sp_s2_r;
  logic [4:0]  ri_s1_r;
  logic [4:0]  ri_s2_r;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
      sp_s1_r <= '0;
      sp_s2_r <= '0;
      ri_s1_r <= '0;
      ri_s2_r <= '0;
    end else begin
      en_s1_r <= enable_i;
      en_s2_r <= en_s1_r;
      sp_s1_r <= output_setpoint_strap_i;
      sp_s2_r <= sp_s1_r;
      ri_s1_r <= setpoint_res_idx_i;
      ri_s2_r <= ri_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Time base and lookup
  logic                     tick;
  logic                     restart;
  logic [css_pkg::MV_W-1:0] rom_mv;

  css_ms_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .restart_i (restart),
    .tick_o    (tick)
  );

  css_res_rom u_rom (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .idx_i     (ri_s2_r),
    .mv_o      (rom_mv)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state
  css_pkg::css_state_e       st_r;
  css_pkg::css_state_e       st_nxt;
  logic [css_pkg::MS_W-1:0]  ms_r;
  logic [css_pkg::MS_W-1:0]  ms_nxt;
  logic [css_pkg::MV_W-1:0]  tgt_r;
  logic [css_pkg::MV_W-1:0]  tgt_nxt;
  logic [css_pkg::MV_W:0]    ceil_r;
  logic [css_pkg::MV_W:0]    ceil_nxt;
  logic [css_pkg::MS_W-1:0]  dly_r;
  logic [css_pkg::MS_W-1:0]  dly_nxt;
  logic [css_pkg::MS_W-1:0]  rmp_r;
  logic [css_pkg::MS_W-1:0]  rmp_nxt;
  logic [15:0]               rd_r;
  logic [15:0]               rd_nxt;
  logic [css_pkg::MV_W-1:0]  strap_mv;
  logic [css_pkg::MS_W-1:0]  eff_dly;
  logic                      bus_open;

  // Strap decode; resistor class uses the lookup
  always_comb begin
    case (sp_s2_r)
      css_pkg::STRAP_LOW:  strap_mv = css_pkg::MV_LOW;
      css_pkg::STRAP_OPEN: strap_mv = css_pkg::MV_OPEN;
      css_pkg::STRAP_HIGH: strap_mv = css_pkg::MV_HIGH;
      default:             strap_mv = rom_mv;
    endcase
  end

  // Pre-ramp delay never shorter than the fixed minimum
  assign eff_dly  = (dly_r < css_pkg::MIN_DELAY_MS) ? css_pkg::MIN_DELAY_MS : dly_r;
  assign bus_open = (st_r != css_pkg::CSS_NVM) && (st_r != css_pkg::CSS_STRAP);
  assign restart  = (st_r != st_nxt);

  // Next-state, settings and bus handling
  always_comb begin
    st_nxt   = st_r;
    ms_nxt   = ms_r;
    tgt_nxt  = tgt_r;
    ceil_nxt = ceil_r;
    dly_nxt  = dly_r;
    rmp_nxt  = rmp_r;
    rd_nxt   = '0;
    if (tick) begin
      ms_nxt = ms_r + 1'b1;
    end
    case (st_r)
      css_pkg::CSS_NVM: begin
        if (ms_r >= css_pkg::NVM_CHECK_MS) begin
          if (nvm_valid_i) begin
            tgt_nxt = nvm_target_mv_i;
            dly_nxt = nvm_delay_ms_i;
            rmp_nxt = nvm_ramp_ms_i;
          end
          st_nxt = css_pkg::CSS_STRAP;
        end
      end
      css_pkg::CSS_STRAP: begin
        if (ms_r >= css_pkg::STRAP_LOAD_MS) begin
          tgt_nxt  = strap_mv;
          ceil_nxt = {1'b0, strap_mv} + (css_pkg::MV_W+1)'(strap_mv / css_pkg::CEIL_DIV);
          dly_nxt  = ss_delay_ms_i;
          rmp_nxt  = ss_ramp_ms_i;
          st_nxt   = css_pkg::CSS_READY;
        end
      end
      css_pkg::CSS_READY: begin
        if (en_s2_r) begin
          st_nxt = css_pkg::CSS_DELAY;
        end
      end
      css_pkg::CSS_DELAY: begin
        if (!en_s2_r) begin
          st_nxt = css_pkg::CSS_READY;
        end else if (ms_r >= eff_dly) begin
          st_nxt = css_pkg::CSS_RAMP;
        end
      end
      css_pkg::CSS_RAMP: begin
        if (!en_s2_r) begin
          st_nxt = css_pkg::CSS_READY;
        end else if (ms_r >= rmp_r) begin
          st_nxt = css_pkg::CSS_ON;
        end
      end
      css_pkg::CSS_ON: begin
        if (!en_s2_r) begin
          st_nxt = css_pkg::CSS_READY;
        end
      end
      default: st_nxt = css_pkg::CSS_NVM;
    endcase
    if (restart) begin
      ms_nxt = '0;
    end
    // Bus accesses only once loading is complete
    if (bus_open && bus_wr_i) begin
      case (bus_addr_i)
        A_TARGET: begin
          if (bus_wdata_i[css_pkg::MV_W-1:0] >= css_pkg::MV_MIN &&
              bus_wdata_i[css_pkg::MV_W-1:0] <= css_pkg::MV_MAX) begin
            tgt_nxt = bus_wdata_i[css_pkg::MV_W-1:0];
          end
        end
        A_DELAY:   dly_nxt = bus_wdata_i[css_pkg::MS_W-1:0];
        A_RESTORE: begin
          st_nxt = css_pkg::CSS_NVM;
          ms_nxt = '0;
        end
        default: ;
      endcase
    end
    if (bus_open && bus_rd_i) begin
      case (bus_addr_i)
        A_TARGET: rd_nxt = {3'h0, tgt_r};
        A_DELAY:  rd_nxt = {8'h00, dly_r};
        A_STATUS: rd_nxt = {13'h0000, 3'(st_r)};
        default:  rd_nxt = {2'h0, ceil_r};
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r   <= css_pkg::CSS_NVM;
      ms_r   <= '0;
      tgt_r  <= css_pkg::MV_MIN;
      ceil_r <= '0;
      dly_r  <= '0;
      rmp_r  <= '0;
      rd_r   <= '0;
    end else begin
      st_r   <= st_nxt;
      ms_r   <= ms_nxt;
      tgt_r  <= tgt_nxt;
      ceil_r <= ceil_nxt;
      dly_r  <= dly_nxt;
      rmp_r  <= rmp_nxt;
      rd_r   <= rd_nxt;
    end
  end

  // Status outputs registered from state
  logic rdy_r;
  logic rmp_o_r;
  logic on_r;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdy_r   <= 1'b0;
      rmp_o_r <= 1'b0;
      on_r    <= 1'b0;
    end else begin
      rdy_r   <= bus_open;
      rmp_o_r <= (st_r == css_pkg::CSS_RAMP);
      on_r    <= (st_r == css_pkg::CSS_RAMP) || (st_r == css_pkg::CSS_ON);
    end
  end

  assign bus_rdata_o            = rd_r;
  assign ready_o                = rdy_r;
  assign ramp_o                 = rmp_o_r;
  assign output_on_o            = on_r;
  assign target_mv_o            = tgt_r;
  assign output_ceiling_limit_o = ceil_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_init_busy;
    (st_r == css_pkg::CSS_NVM) || (st_r == css_pkg::CSS_STRAP);
  endsequence

  a_no_en_init: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    s_init_busy |=> (st_r != css_pkg::CSS_DELAY)) else $error("enable acted during init");
  a_restore_rerun: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (bus_open && bus_wr_i && bus_addr_i == A_RESTORE) |=> (st_r == css_pkg::CSS_NVM))
    else $error("restore ignored");
  a_nvm_min_time: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (st_r == css_pkg::CSS_NVM && st_nxt == css_pkg::CSS_STRAP) |-> ms_r >= css_pkg::NVM_CHECK_MS)
    else $error("memory check too short");
  a_delay_min: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (st_r == css_pkg::CSS_DELAY && st_nxt == css_pkg::CSS_RAMP) |-> ms_r >= css_pkg::MIN_DELAY_MS)
    else $error("pre-ramp delay under minimum");
  a_delay_full: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (st_r == css_pkg::CSS_DELAY && st_nxt == css_pkg::CSS_RAMP) |-> ms_r >= dly_r)
    else $error("configured delay cut short");
  a_ready_out: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $rose(bus_open) |=> ready_o) else $error("ready not reported");
  a_target_range: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (st_r != css_pkg::CSS_NVM) |-> (target_mv_o >= css_pkg::MV_MIN && target_mv_o <= css_pkg::MV_MAX))
    else $error("target out of range");
  a_strap_low: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (st_r == css_pkg::CSS_STRAP && st_nxt == css_pkg::CSS_READY && sp_s2_r == css_pkg::STRAP_LOW)
    |=> target_mv_o == css_pkg::MV_LOW) else $error("low strap wrong setpoint");
  a_ramp_start: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (st_r == css_pkg::CSS_DELAY && st_nxt == css_pkg::CSS_RAMP) |=> ##1 ramp_o)
    else $error("ramp not started");

endmodule : css_sequencer

/* design/css_pkg.sv */
/*
  Constants for the converter start-up sequencer: timing, strap codes,
  setpoint encodings (millivolts) and the state enumeration.
  Assumes a 40 MHz reference clock.
*/
package css_pkg;

  // Clock rate and time base
  localparam int unsigned CLK_HZ       = 40000000;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / MS_PER_S;
  localparam int unsigned TICK_W       = 16;

  // Interval lengths in milliseconds
  localparam logic [7:0] NVM_CHECK_MS  = 8'h0A;   // Upper end of 5 to 10 ms
  localparam logic [7:0] STRAP_LOAD_MS = 8'h01;
  localparam logic [7:0] MIN_DELAY_MS  = 8'h02;
  localparam int unsigned MS_W         = 8;

  // Strap class codes: low, open, high and resistor
  localparam logic [1:0] STRAP_LOW     = 2'h0;
  localparam logic [1:0] STRAP_OPEN    = 2'h1;
  localparam logic [1:0] STRAP_HIGH    = 2'h2;
  localparam logic [1:0] STRAP_RES     = 2'h3;

  // Setpoints in millivolts
  localparam int unsigned MV_W         = 13;
  localparam logic [12:0] MV_LOW       = 13'h04B0; // 1.2 V
  localparam logic [12:0] MV_OPEN      = 13'h05DC; // 1.5 V
  localparam logic [12:0] MV_HIGH      = 13'h0CE4; // 3.3 V
  localparam logic [12:0] MV_MIN       = 13'h0258; // 0.6 V
  localparam logic [12:0] MV_MAX       = 13'h1388; // 5.0 V
  localparam int unsigned RES_ENTRIES  = 31;
  localparam int unsigned RES_IDX_W    = 5;
  localparam int unsigned CEIL_DIV     = 10;     // Ceiling is 10 % above

  // Sequencer states
  typedef enum logic [2:0] {
    CSS_NVM,
    CSS_STRAP,
    CSS_READY,
    CSS_DELAY,
    CSS_RAMP,
    CSS_ON
  } css_state_e;

endpackage : css_pkg

/* design/css_ms_tick.sv */
/*
  Millisecond time base: one-cycle pulse every TICK_CYCLES clocks.
  Assumes the clock rate named in css_pkg.
*/
`timescale 1ns/100ps
module css_ms_tick #(
  parameter int unsigned TICK_CYCLES = css_pkg::TICK_CYCLES  // Clocks per millisecond tick
) (
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  input  wire logic restart_i,
  output logic      tick_o
);

  logic [css_pkg::TICK_W-1:0] cnt_r;
  logic [css_pkg::TICK_W-1:0] cnt_nxt;
  logic                       tick_r;
  logic                       tick_nxt;

  // Divider with restart so intervals start aligned
  always_comb begin
    tick_nxt = 1'b0;
    if (restart_i) begin
      cnt_nxt = '0;
    end else if (cnt_r == css_pkg::TICK_W'(TICK_CYCLES - 1)) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

endmodule : css_ms_tick

/* design/css_res_rom.sv */
/*
  Resistor-code to setpoint lookup, registered read data.
  Assumes index 0 is the 10 kohm entry, 30 the 178 kohm entry.
*/
`timescale 1ns/100ps
module css_res_rom (
  input  wire logic                          ref_clk_i,
  input  wire logic                          resetn_i,
  input  wire logic [css_pkg::RES_IDX_W-1:0] idx_i,
  output logic      [css_pkg::MV_W-1:0]      mv_o
);

  logic [css_pkg::MV_W-1:0] mv_r;
  logic [css_pkg::MV_W-1:0] mv_nxt;

  // Table from 0.6 V up to 3.3 V, then 5.0 V at the top
  always_comb begin
    case (idx_i)
      5'h00: mv_nxt = 13'h0258;
      5'h01: mv_nxt = 13'h02BC;
      5'h02: mv_nxt = 13'h02EE;
      5'h03: mv_nxt = 13'h0320;
      5'h04: mv_nxt = 13'h0384;
      5'h05: mv_nxt = 13'h03E8;
      5'h06: mv_nxt = 13'h044C;
      5'h07: mv_nxt = 13'h04B0;
      5'h08: mv_nxt = 13'h04E2;
      5'h09: mv_nxt = 13'h0514;
      5'h0A: mv_nxt = 13'h0578;
      5'h0B: mv_nxt = 13'h05DC;
      5'h0C: mv_nxt = 13'h0640;
      5'h0D: mv_nxt = 13'h06A4;
      5'h0E: mv_nxt = 13'h0708;
      5'h0F: mv_nxt = 13'h076C;
      5'h10: mv_nxt = 13'h07D0;
      5'h11: mv_nxt = 13'h0834;
      5'h12: mv_nxt = 13'h0898;
      5'h13: mv_nxt = 13'h08FC;
      5'h14: mv_nxt = 13'h0960;
      5'h15: mv_nxt = 13'h09C4;
      5'h16: mv_nxt = 13'h0A28;
      5'h17: mv_nxt = 13'h0A8C;
      5'h18: mv_nxt = 13'h0AF0;
      5'h19: mv_nxt = 13'h0B54;
      5'h1A: mv_nxt = 13'h0BB8;
      5'h1B: mv_nxt = 13'h0C1C;
      5'h1C: mv_nxt = 13'h0C80;
      5'h1D: mv_nxt = 13'h0CE4;
      5'h1E: mv_nxt = 13'h1388;
      default: mv_nxt = 13'h1388;   // Out of range clamps to top
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mv_r <= '0;
    end else begin
      mv_r <= mv_nxt;
    end
  end

  assign mv_o = mv_r;

endmodule : css_res_rom

/* verification/css_host_model.sv */
/*
  Host-side model: register strobes and the enable pin.
  Assumes a slave that samples on the rising edge and answers a read
  one cycle later without wait states.
*/
`timescale 1ns/100ps
module css_host_model (
  input  wire logic        ref_clk_i,
  input  wire logic [15:0] bus_rdata_i,
  output logic             enable_o,
  output logic             bus_wr_o,
  output logic             bus_rd_o,
  output logic [1:0]       bus_addr_o,
  output logic [15:0]      bus_wdata_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle levels at time zero
  initial begin
    enable_o    = 1'b0;
    bus_wr_o    = 1'b0;
    bus_rd_o    = 1'b0;
    bus_addr_o  = 2'h0;
    bus_wdata_o = 16'h0000;
  end

  // Enable moves only after the reference clock is already running
  task set_en(input logic v);
    @(posedge ref_clk_i);
    enable_o <= v;
  endtask : set_en

  // One-cycle write; released lines show the inverse of their last value
  task wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    bus_wr_o    <= 1'b1;
    bus_addr_o  <= a;
    bus_wdata_o <= d;
    @(posedge ref_clk_i);
    bus_wr_o    <= 1'b0;
    bus_addr_o  <= ~a;
    bus_wdata_o <= ~d;
  endtask : wr

  // One-cycle read; data taken in the cycle after the strobe
  task rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    bus_rd_o   <= 1'b1;
    bus_addr_o <= a;
    @(posedge ref_clk_i);
    bus_rd_o   <= 1'b0;
    bus_addr_o <= ~a;
    #1;
    d = bus_rdata_i;
  endtask : rd
endmodule : css_host_model

/* verification/testbench.sv */
/*
  Self-checking bench for the start-up sequencer: integer model of
  setpoints, ceiling and timing windows, host model on the bus.
  Assumes the interval lengths of css_pkg with the millisecond tick cut
  to MS clocks; the run spans about 66 such ticks.
*/
`timescale 1ns/100ps
module testbench;
  localparam int MS    = 400;  // Short tick keeps the run to tens of thousands of clocks
  localparam int LIMIT = 80 * MS;
  logic        ref_clk_i;
  logic        resetn_i;
  logic        enable;
  logic [1:0]  strap;
  logic [4:0]  res_idx;
  logic        nvm_valid;
  logic [12:0] nvm_target;
  logic [7:0]  nvm_delay;
  logic [7:0]  nvm_ramp;
  logic [7:0]  ss_delay;
  logic [7:0]  ss_ramp;
  logic        bus_wr;
  logic        bus_rd;
  logic [1:0]  bus_addr;
  logic [15:0] bus_wdata;
  logic [15:0] bus_rdata;
  logic        ready;
  logic        ramp;
  logic        on;
  logic [12:0] target;
  logic [13:0] ceil;
  logic [15:0] rv;
  logic [15:0] wv;
  int          failures;
  int          total_checks;
  int          cyc;
  int          seed;
  int          t0;
  int          n;
  int          i;
  int          exp_mv;
  int          code;
  int          idx;
  int          res_mv[31] = '{600, 700, 750, 800, 900, 1000, 1100, 1200, 1250, 1300, 1400,
    1500, 1600, 1700, 1800, 1900, 2000, 2100, 2200, 2300, 2400, 2500, 2600, 2700, 2800,
    2900, 3000, 3100, 3200, 3300, 5000};
  int          fix_wr[5] = '{1000, 6000, 500, 600, 5000};

  ////////////////////////////////////////////////////////////////////////////
  // Design and host model
  css_sequencer #(.TICK_CYCLES(MS)) css_sequencer_inst (
    .ref_clk_i              (ref_clk_i),
    .resetn_i               (resetn_i),
    .enable_i               (enable),
    .output_setpoint_strap_i(strap),
    .setpoint_res_idx_i     (res_idx),
    .nvm_valid_i            (nvm_valid),
    .nvm_target_mv_i        (nvm_target),
    .nvm_delay_ms_i         (nvm_delay),
    .nvm_ramp_ms_i          (nvm_ramp),
    .ss_delay_ms_i          (ss_delay),
    .ss_ramp_ms_i           (ss_ramp),
    .bus_wr_i               (bus_wr),
    .bus_addr_i             (bus_addr),
    .bus_wdata_i            (bus_wdata),
    .bus_rd_i               (bus_rd),
    .bus_rdata_o            (bus_rdata),
    .ready_o                (ready),
    .ramp_o                 (ramp),
    .output_on_o            (on),
    .target_mv_o            (target),
    .output_ceiling_limit_o (ceil)
  );
  css_host_model css_host_model_inst (
    .ref_clk_i  (ref_clk_i),
    .bus_rdata_i(bus_rdata),
    .enable_o   (enable),
    .bus_wr_o   (bus_wr),
    .bus_rd_o   (bus_rd),
    .bus_addr_o (bus_addr),
    .bus_wdata_o(bus_wdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Setpoint model: strap class or resistor table, in millivolts
  function automatic int strap_mv(input int c, input int k);
    case (c)
      0: return 1200;
      1: return 1500;
      2: return 3300;
      default: return res_mv[k];
    endcase
  endfunction : strap_mv

  // Value comparison
  task chk(input string nm, input int e, input logic [15:0] g);
    total_checks++;
    if (g !== e[15:0]) begin
      failures++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk

  // Interval comparison against a window of cycles
  task chk_rng(input string nm, input int lo, input int hi, input int g);
    total_checks++;
    if (g < lo || g > hi) begin
      failures++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng

  // Bounded wait for ready (0), ramp (1) or output on (2) to reach a level
  task wait_sig(input int w, input logic v);
    logic s;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      #1;
      n++;
      s = (w == 0) ? ready : (w == 1) ? ramp : on;
    end while (s !== v && n < 20 * MS);
    // A wait that runs out is a mismatch
    if (s !== v) begin
      failures++;
      $display("[FAIL] wait %0d expected %0d seen %0d", w, v, s);
    end
  endtask : wait_sig

  // Verdict
  task end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      failures++;
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    seed = 42;
    failures = 0;
    total_checks = 0;
    cyc = 0;
    resetn_i <= 1'b0;
    strap <= css_pkg::STRAP_HIGH;
    res_idx <= 5'h00;
    nvm_valid <= 1'b0;
    nvm_target <= $random(seed);
    nvm_delay <= $random(seed);
    nvm_ramp <= $random(seed);
    ss_delay <= 8'h00;
    ss_ramp <= 8'h02;
    css_host_model_inst.set_en(1'b1);
    repeat (7) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t0 = cyc;
    repeat (MS) @(posedge ref_clk_i);
    css_host_model_inst.wr(2'h0, 16'h07D0);
    wait_sig(0, 1'b1);
    chk_rng("init time", 5 * MS, 12 * MS, cyc - t0);
    t0 = cyc;
    chk("target", 3300, target);
    chk("ceiling", 3630, ceil);
    css_host_model_inst.rd(2'h0, rv);
    chk("bus target", 3300, rv);
    css_host_model_inst.rd(2'h1, rv);
    chk("bus delay", 0, rv);
    wait_sig(1, 1'b1);
    chk_rng("pre-ramp", 2 * MS - 5, 3 * MS + 10, cyc - t0);
    t0 = cyc;
    wait_sig(1, 1'b0);
    chk_rng("ramp time", 2 * MS - 5, 3 * MS + 10, cyc - t0);
    chk("output on", 1, on);
    css_host_model_inst.rd(2'h3, rv);
    chk("bus status", 5, rv);
    // Target writes: boundaries, refusals and random values
    exp_mv = 3300;
    for (i = 0; i < 10; i++) begin
      wv = (i < 5) ? fix_wr[i][15:0] : ($random(seed) & 16'h1FFF);
      css_host_model_inst.wr(2'h0, wv);
      if (wv >= 600 && wv <= 5000)
        exp_mv = wv;
      css_host_model_inst.rd(2'h0, rv);
      chk("bus target", exp_mv, rv);
      chk("target", exp_mv, target);
      chk("ceiling", 3630, ceil);
    end
    css_host_model_inst.rd(2'h2, rv);
    chk("bus ceiling", 3630, rv);
    // Longer configured delay is waited out in full
    css_host_model_inst.set_en(1'b0);
    wait_sig(2, 1'b0);
    chk("ready", 1, ready);
    css_host_model_inst.wr(2'h1, 16'h0003);
    css_host_model_inst.rd(2'h1, rv);
    chk("bus delay", 3, rv);
    css_host_model_inst.set_en(1'b1);
    t0 = cyc;
    wait_sig(1, 1'b1);
    chk_rng("long delay", 3 * MS - 5, 4 * MS + 10, cyc - t0);
    css_host_model_inst.set_en(1'b0);
    wait_sig(2, 1'b0);
    // Restore with low, open and resistor straps; enable pulsed during loading
    for (i = 0; i < 4; i++) begin
      code = (i == 0) ? 0 : (i == 1) ? 1 : 3;
      idx = (i == 2) ? 30 : (($random(seed) & 16'h7FFF) % 31);
      strap <= code[1:0];
      res_idx <= idx[4:0];
      ss_delay <= idx[7:0];
      css_host_model_inst.wr(2'h2, 16'h0000);
      repeat (2) @(posedge ref_clk_i);
      #1;
      chk("ready drop", 0, ready);
      css_host_model_inst.set_en(1'b1);
      repeat (MS) @(posedge ref_clk_i);
      css_host_model_inst.set_en(1'b0);
      wait_sig(0, 1'b1);
      exp_mv = strap_mv(code, idx);
      chk("target", exp_mv, target);
      chk("ceiling", exp_mv + exp_mv / 10, ceil);
      css_host_model_inst.rd(2'h1, rv);
      chk("bus delay", idx, rv);
      strap <= ~code[1:0];
      repeat (10) @(posedge ref_clk_i);
      #1;
      chk("target held", exp_mv, target);
      if (i == 0) begin
        repeat (3 * MS) @(posedge ref_clk_i);
        #1;
        chk("no ramp", 0, on);
      end
    end
    end_of_test();
  end
endmodule : testbench
